// *** pkg/swf_defs.svh ***
// constants for the status word flag logic: offsets, bit positions, reset values, arithmetic limits
// Behaviour
// - add/subtract sets carry on MSB carry/borrow
// - multiply and divide always clear carry
// - decimal adjust carry reports BCD sum over 99
// - compare-jump carry means first unsigned below second
// - aux carry on carry/borrow at bit 4
// - bit 5 is a free software flag
// - bank bits select working register RAM bank
// - add overflow is carry6 xor carry7
// - subtract overflow is borrow6 xor borrow7
// - multiply overflow when product high byte nonzero
// - divide clears overflow, sets it on zero divisor
// - status word at D0H, resets zero, parity read-only
// - parity follows accumulator odd one count
`ifndef SWF_DEFS_SVH
`define SWF_DEFS_SVH

// bus widths
`define SWF_ADDR_W 8
`define SWF_DATA_W 32

// register byte offsets
`define SWF_OFS_ACC 8'h00
`define SWF_OFS_AUXB 8'h04
`define SWF_OFS_OPND 8'h08
`define SWF_OFS_CMD 8'h0C
`define SWF_OFS_BITOP 8'h10
`define SWF_OFS_BANK 8'h14
`define SWF_OFS_PSW 8'hD0

// status word bit positions
`define SWF_BIT_CARRY 7
`define SWF_BIT_AUX 6
`define SWF_BIT_USER0 5
`define SWF_BIT_BANK_HI 4
`define SWF_BIT_BANK_LO 3
`define SWF_BIT_OVF 2
`define SWF_BIT_USER1 1
`define SWF_BIT_PARITY 0

// reset values
`define SWF_PSW_RESET 8'h00
`define SWF_BYTE_RESET 8'h00

// bit-op and command register fields
`define SWF_BITOP_IDX_HI 2
`define SWF_BITOP_VAL 3
`define SWF_CMD_UNEQ 4

// working register bank stride is eight bytes
`define SWF_BANK_SHIFT 3

// decimal adjust limits
`define SWF_NIB_MAX 4'h9
`define SWF_HI_MAX 5'h09
`define SWF_LO_ADJ 9'h006
`define SWF_HI_ADJ 9'h060

// bus responses
`define SWF_RESP_OKAY 2'b00
`define SWF_RESP_SLVERR 2'b10

`endif

// *** pkg/swf_pkg.sv ***
// types shared by the status word flag logic
package swf_pkg;

  // arithmetic operations that touch the flags
  typedef enum logic [3:0] {
    swf_op_none = 4'h0,
    swf_op_plain_addition = 4'h1,
    swf_op_addition_with_carry_in = 4'h2,
    swf_op_subtract_with_borrow = 4'h3,
    swf_op_byte_product = 4'h4,
    swf_op_byte_quotient = 4'h5,
    swf_op_decimal_adjust_acc = 4'h6,
    swf_op_compare_jump_unequal = 4'h7
  } swf_op_type;

  // complete state of the top module
  typedef struct packed {
    logic carry_flag;
    logic aux_carry_flag;
    logic user_flag_zero;
    logic bank_select_hi;
    logic bank_select_lo;
    logic overflow_flag;
    logic user_flag_one;
    logic [7:0] acc;
    logic [7:0] aux_operand;
    logic [7:0] operand;
    logic [3:0] last_op;
    logic unequal;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } swf_state_type;

endpackage

// *** src/swf_flag_unit.sv ***
// combinational arithmetic and flag generation for one operation
`timescale 1ns/1ps
`default_nettype none
`include "swf_defs.svh"

module swf_flag_unit (
  // operation select
  input wire swf_pkg::swf_op_type op,
  // operands and current flags
  input wire logic [7:0] acc,
  input wire logic [7:0] aux_operand,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire logic aux_in,
  input wire logic ovf_in,
  // results
  output logic [7:0] acc_out,
  output logic [7:0] aux_out,
  output logic carry_out,
  output logic aux_carry_out,
  output logic ovf_out,
  output logic unequal
);
  import swf_pkg::*;

  // wide intermediates so every carry and borrow is visible
  logic cin;
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic [7:0] low7;
  logic [15:0] prod;
  logic [8:0] adj1;
  logic [8:0] adj2;

  /////////////////////////////////////////////////////////////////////////////
  // one case per operation; each starts from the old values
  always_comb begin
    acc_out = acc;
    aux_out = aux_operand;
    carry_out = carry_in;
    aux_carry_out = aux_in;
    ovf_out = ovf_in;
    unequal = 1'b0;
    cin = (op == swf_op_addition_with_carry_in) ? carry_in : 1'b0;
    sum9 = '0;
    lo5 = '0;
    low7 = '0;
    prod = '0;
    adj1 = '0;
    adj2 = '0;
    unique case (op)
      swf_op_plain_addition, swf_op_addition_with_carry_in: begin
        sum9 = {1'b0, acc} + {1'b0, operand} + 9'(cin);
        lo5 = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + 5'(cin);
        low7 = {1'b0, acc[6:0]} + {1'b0, operand[6:0]} + 8'(cin);
        acc_out = sum9[7:0];
        carry_out = sum9[8];
        aux_carry_out = lo5[4];
        ovf_out = low7[7] ^ sum9[8];
      end
      swf_op_subtract_with_borrow: begin
        // a set top bit after the subtract is the borrow
        sum9 = {1'b0, acc} - {1'b0, operand} - 9'(carry_in);
        lo5 = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - 5'(carry_in);
        low7 = {1'b0, acc[6:0]} - {1'b0, operand[6:0]} - 8'(carry_in);
        acc_out = sum9[7:0];
        carry_out = sum9[8];
        aux_carry_out = lo5[4];
        ovf_out = low7[7] ^ sum9[8];
      end
      swf_op_byte_product: begin
        prod = acc * aux_operand;
        acc_out = prod[7:0];
        aux_out = prod[15:8];
        carry_out = 1'b0;
        ovf_out = |prod[15:8];
      end
      swf_op_byte_quotient: begin
        carry_out = 1'b0;
        if (aux_operand == `SWF_BYTE_RESET) begin
          // results are undefined here; both bytes are simply kept
          ovf_out = 1'b1;
        end else begin
          acc_out = acc / aux_operand;
          aux_out = acc % aux_operand;
          ovf_out = 1'b0;
        end
      end
      swf_op_decimal_adjust_acc: begin
        // low digit, then high digit; carry is only ever raised here
        adj1 = {1'b0, acc};
        if ((acc[3:0] > `SWF_NIB_MAX) || aux_in) begin
          adj1 = adj1 + `SWF_LO_ADJ;
        end
        adj2 = adj1;
        if ((adj1[8:4] > `SWF_HI_MAX) || carry_in) begin
          adj2 = adj1 + `SWF_HI_ADJ;
        end
        acc_out = adj2[7:0];
        carry_out = carry_in | adj1[8] | adj2[8];
      end
      swf_op_compare_jump_unequal: begin
        carry_out = (acc < operand);
        unequal = (acc != operand);
      end
      default: begin
        // unknown codes change no byte or flag; unequal is driven low
        acc_out = acc;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** src/swf_status_word.sv ***
// status word flag logic with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "swf_defs.svh"

module swf_status_word (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [`SWF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [`SWF_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [`SWF_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [`SWF_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core-side view of the status word
  output logic [7:0] status_word,
  output logic parity_flag,
  output logic [7:0] bank_base_addr
);
  import swf_pkg::*;

  /////////////////////////////////////////////////////////////////////////////
  // state and helpers

  swf_state_type st_r;     // every flip-flop of the block
  swf_state_type st_nxt;   // next value of all of them

  logic aw_take;           // address handshake this cycle
  logic w_take;            // data handshake this cycle
  logic ar_take;           // read address handshake this cycle
  logic aw_have;           // write address available (held or arriving)
  logic w_have;            // write data available (held or arriving)
  logic wr_go;             // write is carried out this cycle
  logic [7:0] wr_addr;     // address of the write being carried out
  logic [31:0] wr_data;    // data of the write being carried out
  logic [3:0] wr_strb;     // strobes of the write being carried out
  logic [7:0] wr_byte;     // lane 0 of the write data
  logic [7:0] psw_now;     // status word as software reads it
  logic [7:0] psw_new;     // status word after a software write
  logic [7:0] rd_word;     // selected byte for a read
  logic rd_hit;            // read address is mapped
  logic wr_hit;            // write address is mapped

  // flag unit connections
  swf_op_type fu_op;
  logic [7:0] fu_acc;
  logic [7:0] fu_aux;
  logic fu_carry;
  logic fu_aux_carry;
  logic fu_ovf;
  logic fu_unequal;

  /////////////////////////////////////////////////////////////////////////////
  // handshake outputs

  // one write at a time: a slot stays closed while its item waits or the
  // response is still pending, which back-pressures the master cleanly
  assign s_axi_awready = !st_r.aw_full && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_full && !st_r.bvalid;
  // one read at a time: no new address until the data is taken
  assign s_axi_arready = !st_r.rvalid;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign aw_have = st_r.aw_full || aw_take;
  assign w_have = st_r.w_full || w_take;
  assign wr_go = aw_have && w_have && !st_r.bvalid;

  // take held items first, otherwise those on the channel right now
  assign wr_addr = st_r.aw_full ? st_r.aw_addr : s_axi_awaddr;
  assign wr_data = st_r.w_full ? st_r.w_data : s_axi_wdata;
  assign wr_strb = st_r.w_full ? st_r.w_strb : s_axi_wstrb;
  assign wr_byte = wr_data[7:0];

  /////////////////////////////////////////////////////////////////////////////
  // bus-side outputs straight from flip-flops

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  /////////////////////////////////////////////////////////////////////////////
  // status word view

  // parity is pure logic on the accumulator, so it can never go stale
  assign parity_flag = ^st_r.acc;

  // bit 0 always shows parity; software cannot store into it
  assign psw_now = {st_r.carry_flag, st_r.aux_carry_flag, st_r.user_flag_zero,
                    st_r.bank_select_hi, st_r.bank_select_lo, st_r.overflow_flag,
                    st_r.user_flag_one, parity_flag};
  assign status_word = psw_now;

  // bank n covers n*8 to n*8+7 of internal RAM
  assign bank_base_addr = 8'({st_r.bank_select_hi, st_r.bank_select_lo}) << `SWF_BANK_SHIFT;

  /////////////////////////////////////////////////////////////////////////////
  // flag unit: the opcode comes from the command write under way

  assign fu_op = swf_op_type'(wr_byte[3:0]);

  swf_flag_unit u_flag_unit (
    .op(fu_op),
    .acc(st_r.acc),
    .aux_operand(st_r.aux_operand),
    .operand(st_r.operand),
    .carry_in(st_r.carry_flag),
    .aux_in(st_r.aux_carry_flag),
    .ovf_in(st_r.overflow_flag),
    .acc_out(fu_acc),
    .aux_out(fu_aux),
    .carry_out(fu_carry),
    .aux_carry_out(fu_aux_carry),
    .ovf_out(fu_ovf),
    .unequal(fu_unequal)
  );

  /////////////////////////////////////////////////////////////////////////////
  // software view of a write to the status word, whole byte or single bit
  always_comb begin
    psw_new = psw_now;
    if (wr_addr == `SWF_OFS_PSW) begin
      // whole-byte write
      psw_new = wr_byte;
    end else begin
      // bit-addressed write: one bit replaced, the others untouched
      psw_new[wr_byte[`SWF_BITOP_IDX_HI:0]] = wr_byte[`SWF_BITOP_VAL];
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // address decode for writes and reads
  always_comb begin
    unique case (wr_addr)
      `SWF_OFS_ACC, `SWF_OFS_AUXB, `SWF_OFS_OPND, `SWF_OFS_CMD, `SWF_OFS_BITOP, `SWF_OFS_PSW: begin
        wr_hit = 1'b1;
      end
      default: begin
        // bank register is read-only, unmapped addresses are refused
        wr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `SWF_OFS_ACC: begin
        rd_word = st_r.acc;
      end
      `SWF_OFS_AUXB: begin
        rd_word = st_r.aux_operand;
      end
      `SWF_OFS_OPND: begin
        rd_word = st_r.operand;
      end
      `SWF_OFS_CMD: begin
        // last opcode and the compare result
        rd_word = `SWF_BYTE_RESET;
        rd_word[3:0] = st_r.last_op;
        rd_word[`SWF_CMD_UNEQ] = st_r.unequal;
      end
      `SWF_OFS_BITOP: begin
        rd_word = `SWF_BYTE_RESET;
      end
      `SWF_OFS_BANK: begin
        rd_word = bank_base_addr;
      end
      `SWF_OFS_PSW: begin
        rd_word = psw_now;
      end
      default: begin
        rd_word = `SWF_BYTE_RESET;
        rd_hit = 1'b0;
      end
    endcase
  end

  /////////////////////////////////////////////////////////////////////////////
  // next state: channels, register writes and operations
  always_comb begin
    st_nxt = st_r;

    // hold whichever write half arrives first
    if (aw_take) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      st_nxt.w_full = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end

    // response taken by the master
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // both halves present: carry out the write and answer
    if (wr_go) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? `SWF_RESP_OKAY : `SWF_RESP_SLVERR;
      // registers are one byte wide and live in lane 0 only
      if (wr_hit && wr_strb[0]) begin
        unique case (wr_addr)
          `SWF_OFS_ACC: begin
            st_nxt.acc = wr_byte;
          end
          `SWF_OFS_AUXB: begin
            st_nxt.aux_operand = wr_byte;
          end
          `SWF_OFS_OPND: begin
            st_nxt.operand = wr_byte;
          end
          `SWF_OFS_CMD: begin
            // the operation completes in this cycle; flags it does not
            // define come back unchanged from the flag unit
            st_nxt.last_op = wr_byte[3:0];
            st_nxt.acc = fu_acc;
            st_nxt.aux_operand = fu_aux;
            st_nxt.carry_flag = fu_carry;
            st_nxt.aux_carry_flag = fu_aux_carry;
            st_nxt.overflow_flag = fu_ovf;
            st_nxt.unequal = fu_unequal;
          end
          default: begin
            // status word, whole or bitwise; bit 0 is dropped
            st_nxt.carry_flag = psw_new[`SWF_BIT_CARRY];
            st_nxt.aux_carry_flag = psw_new[`SWF_BIT_AUX];
            st_nxt.user_flag_zero = psw_new[`SWF_BIT_USER0];
            st_nxt.bank_select_hi = psw_new[`SWF_BIT_BANK_HI];
            st_nxt.bank_select_lo = psw_new[`SWF_BIT_BANK_LO];
            st_nxt.overflow_flag = psw_new[`SWF_BIT_OVF];
            st_nxt.user_flag_one = psw_new[`SWF_BIT_USER1];
          end
        endcase
      end
    end

    // read data taken by the master
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // new read: data is captured at the edge that takes the address and is valid in the next cycle
    if (ar_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = {24'h00_0000, rd_word};
      st_nxt.rresp = rd_hit ? `SWF_RESP_OKAY : `SWF_RESP_SLVERR;
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // register everything; synchronous reset clears the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// *** test/swf_status_chk.sv ***
// assertion checker for the status word flag logic, bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "swf_defs.svh"

module swf_status_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [`SWF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [`SWF_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`SWF_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic [7:0] status_word,
  input wire logic parity_flag,
  input wire logic [7:0] bank_base_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // a whole status word write taken in one edge, lane 0 enabled
  logic psw_wr;
  assign psw_wr = s_axi_awvalid && s_axi_awready && s_axi_awaddr == `SWF_OFS_PSW
                  && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  a_bank_map: assert property (bank_base_addr == {3'b000, status_word[4:3], 3'b000})
    else $error("bank base does not follow the bank bits");
  a_parity_bit: assert property (status_word[0] == parity_flag)
    else $error("status word bit 0 differs from parity");
  a_reset_clear: assert property ($rose(aresetn) |-> status_word == `SWF_PSW_RESET)
    else $error("status word not clear after reset");
  a_psw_write: assert property (psw_wr |=> status_word[7:1] == $past(s_axi_wdata[7:1]))
    else $error("written status bits not taken");
  a_parity_ro: assert property (psw_wr |=> $stable(parity_flag))
    else $error("status word write moved parity");
  a_flags_hold: assert property ($changed(status_word[7:1]) |-> $rose(s_axi_bvalid))
    else $error("flags changed without a completed write");
  a_psw_okay: assert property (psw_wr |=> s_axi_bvalid && s_axi_bresp == `SWF_RESP_OKAY)
    else $error("status word write not answered okay");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
endmodule

bind swf_status_word swf_status_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .status_word, .parity_flag,
  .bank_base_addr);
`default_nettype wire

// *** test/swf_status_word_bench.sv ***
// self-checking bench for the status word flag logic
`timescale 1ns/1ps
`default_nettype none
`include "swf_defs.svh"

module swf_status_word_bench;
  import swf_pkg::*;
  // clock, reset and bus master side
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  // answers from the block
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, parity_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [7:0] status_word, bank_base_addr;
  logic [1:0] r;
  int fails = 0;
  int tests_run = 0;
  // one operation: operands, preset status word, opcode, expected result and status word
  typedef struct {
    logic [7:0] acc, opnd, auxb, psw_in;
    swf_op_type op;
    logic [7:0] acc_exp, psw_exp;
  } swf_row_type;
  swf_row_type rows [13] = '{
    '{8'h7f, 8'h01, 8'h00, 8'h00, swf_op_plain_addition, 8'h80, 8'h45},
    '{8'hff, 8'h01, 8'h00, 8'h00, swf_op_plain_addition, 8'h00, 8'hc0},
    '{8'h80, 8'h80, 8'h00, 8'h80, swf_op_addition_with_carry_in, 8'h01, 8'h85},
    '{8'h80, 8'h01, 8'h00, 8'h00, swf_op_subtract_with_borrow, 8'h7f, 8'h45},
    '{8'h00, 8'h00, 8'h00, 8'h80, swf_op_subtract_with_borrow, 8'hff, 8'hc0},
    '{8'h10, 8'h00, 8'h10, 8'hc0, swf_op_byte_product, 8'h00, 8'h44},
    '{8'h0f, 8'h00, 8'h11, 8'h84, swf_op_byte_product, 8'hff, 8'h00},
    '{8'h64, 8'h00, 8'h07, 8'he4, swf_op_byte_quotient, 8'h0e, 8'h61},
    '{8'h9a, 8'h00, 8'h00, 8'h00, swf_op_decimal_adjust_acc, 8'h00, 8'h80},
    '{8'h45, 8'h00, 8'h00, 8'h04, swf_op_decimal_adjust_acc, 8'h45, 8'h05},
    '{8'h10, 8'h20, 8'h00, 8'h44, swf_op_compare_jump_unequal, 8'h10, 8'hc5},
    '{8'h20, 8'h20, 8'h00, 8'h80, swf_op_compare_jump_unequal, 8'h20, 8'h01},
    '{8'h01, 8'h01, 8'h00, 8'h1a, swf_op_plain_addition, 8'h02, 8'h1b}};

  swf_status_word dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .status_word, .parity_flag, .bank_base_addr);

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 aclk = ~aclk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one write; ready is raised late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 2) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one idle edge keeps each signal to a single change per time step
    @(posedge aclk);
  endtask

  // one read, same late-ready pattern
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 2) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // print the counts and the verdict, then stop
  task automatic summarize();
    $display("compared %0d, mismatched %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset state and an unmapped read
    chk({24'h0, status_word}, 32'h0000_0000, "status after reset");
    chk({24'h0, bank_base_addr}, 32'h0000_0000, "bank after reset");
    rd(`SWF_OFS_PSW, d, r);
    chk(d, 32'h0000_0000, "status read after reset");
    rd(8'h20, d, r);
    chk({30'h0, r}, {30'h0, `SWF_RESP_SLVERR}, "unmapped read");
    $display("test reset done");
    // table of operations
    foreach (rows[i]) begin
      wr(`SWF_OFS_ACC, {24'h0, rows[i].acc}, r);
      wr(`SWF_OFS_OPND, {24'h0, rows[i].opnd}, r);
      wr(`SWF_OFS_AUXB, {24'h0, rows[i].auxb}, r);
      wr(`SWF_OFS_PSW, {24'h0, rows[i].psw_in}, r);
      wr(`SWF_OFS_CMD, {28'h0, rows[i].op}, r);
      rd(`SWF_OFS_ACC, d, r);
      chk(d, {24'h0, rows[i].acc_exp}, "result byte");
      rd(`SWF_OFS_PSW, d, r);
      chk(d, {24'h0, rows[i].psw_exp}, "status word");
      chk({24'h0, status_word}, {24'h0, rows[i].psw_exp}, "status port");
    end
    $display("test operation table done");
    // every bank choice
    for (int i = 0; i < 4; i++) begin
      wr(`SWF_OFS_PSW, {27'h0, i[1:0], 3'b000}, r);
      chk({24'h0, bank_base_addr}, {27'h0, i[1:0], 3'b000}, "bank base");
    end
    $display("test banks done");
    // parity is read-only and follows the accumulator
    wr(`SWF_OFS_ACC, 32'h0000_0000, r);
    wr(`SWF_OFS_PSW, 32'h0000_00ff, r);
    rd(`SWF_OFS_PSW, d, r);
    chk(d, 32'h0000_00fe, "parity written");
    wr(`SWF_OFS_ACC, 32'h0000_0007, r);
    chk({24'h0, status_word}, 32'h0000_00ff, "odd parity");
    chk({31'h0, parity_flag}, 32'h0000_0001, "parity pin");
    // a write with lane 0 off changes nothing
    s_axi_wstrb <= 4'h0;
    wr(`SWF_OFS_PSW, 32'h0000_0000, r);
    s_axi_wstrb <= 4'hf;
    chk({24'h0, status_word}, 32'h0000_00ff, "masked write");
    $display("test parity done");
    // single-bit set and clear of the user flag
    wr(`SWF_OFS_PSW, 32'h0000_0000, r);
    wr(`SWF_OFS_BITOP, 32'h0000_000d, r);
    chk({24'h0, status_word}, 32'h0000_0021, "bit set");
    wr(`SWF_OFS_BITOP, 32'h0000_0008, r);
    chk({24'h0, status_word}, 32'h0000_0021, "parity bit op");
    wr(`SWF_OFS_BITOP, 32'h0000_0005, r);
    chk({24'h0, status_word}, 32'h0000_0001, "bit clear");
    $display("test bit access done");
    // refused writes
    wr(`SWF_OFS_BANK, 32'h0000_00ff, r);
    chk({30'h0, r}, {30'h0, `SWF_RESP_SLVERR}, "read-only write");
    wr(8'h20, 32'h0000_00ff, r);
    chk({30'h0, r}, {30'h0, `SWF_RESP_SLVERR}, "unmapped write");
    chk({24'h0, status_word}, 32'h0000_0001, "refused writes kept");
    $display("test refused writes done");
    // divide by zero: only the flags are defined
    wr(`SWF_OFS_ACC, 32'h0000_0055, r);
    wr(`SWF_OFS_AUXB, 32'h0000_0000, r);
    wr(`SWF_OFS_PSW, 32'h0000_0080, r);
    wr(`SWF_OFS_CMD, {28'h0, swf_op_byte_quotient}, r);
    rd(`SWF_OFS_PSW, d, r);
    chk({25'h0, d[7:1]}, 32'h0000_0002, "zero divisor flags");
    $display("test zero divisor done");
    // compare of unequal bytes, then a code that no operation uses
    wr(`SWF_OFS_OPND, 32'h0000_0054, r);
    wr(`SWF_OFS_CMD, {28'h0, swf_op_compare_jump_unequal}, r);
    rd(`SWF_OFS_CMD, d, r);
    chk(d, 32'h0000_0017, "compare readback");
    wr(`SWF_OFS_CMD, 32'h0000_000f, r);
    rd(`SWF_OFS_CMD, d, r);
    chk(d, 32'h0000_000f, "unused code readback");
    chk({24'h0, status_word}, 32'h0000_0004, "unused code flags");
    $display("test commands done");
    // mid-run reset, held long enough that no flag change straddles the release
    wr(`SWF_OFS_PSW, 32'h0000_00fe, r);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({24'h0, status_word}, 32'h0000_0000, "status after reset 2");
    chk({24'h0, bank_base_addr}, 32'h0000_0000, "bank after reset 2");
    rd(`SWF_OFS_ACC, d, r);
    chk(d, 32'h0000_0000, "acc after reset 2");
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
